/* logic/sdma_engine.sv */
// Six-channel transfer engine with a host port auxiliary channel.
// Assumes memory answers each phase within its fixed cycle budget and
// that the far bus owner grants external access outside this block.
//
// Notes on behaviour
// - Six channels, each holding one block context
// - Transfers run with no CPU involvement
// - Host port owns a dedicated auxiliary channel
// - Only one external-read, one external-write channel
// - Engine request beats CPU on internal memory
// - Each channel has its own priority
// - Addresses hold, increment, decrement or index
// - Internal phases may wait for sync event
// - Wide elements internal only; external 16-bit
// - Peripheral/external and external/external transfers barred
// - Internal element takes two read, two write cycles
// - Host port shares the bus, slows channels
// - Space code 10 goes to core FIFO
// - All local memory reachable
// - Register window limits readable/writable locations for the six channels; host port accesses are not checked
// - External pages alias onto low three bits
// - Bits 5 and 11 select external access
// - Four-bit sync code, reserved codes never fire
// - External write 9, read 13 cycles minimum
`timescale 1ns/10ps
module sdma_engine
	import sdma_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Channel programming
	input wire logic [NUM_CH-1:0] i_ch_enable,
	input wire logic [NUM_CH*MODE_W-1:0] i_channel_transfer_mode_reg,
	input wire logic [NUM_CH*4-1:0] i_sync_event_select,
	input wire logic [NUM_CH*PRIO_W-1:0] i_ch_priority,
	input wire logic [NUM_CH*ADDR_W-1:0] i_ch_src_start,
	input wire logic [NUM_CH*ADDR_W-1:0] i_ch_dst_start,
	input wire logic [NUM_CH*16-1:0] i_ch_count,
	input wire logic [15:0] i_index,
	input wire logic [CH_W-1:0] i_ext_read_ch,
	input wire logic [CH_W-1:0] i_ext_write_ch,
	input wire logic [NUM_EVENTS-1:0] i_sync_events,
	// Host port auxiliary channel
	input wire logic i_host_port_req,
	input wire logic i_host_port_write,
	input wire logic [ADDR_W-1:0] i_host_port_addr,
	input wire logic [15:0] i_host_port_wdata,
	output logic o_host_port_ack,
	output logic [15:0] o_host_port_rdata,
	// Shared memory bus
	output logic o_mem_req,
	output logic o_mem_write,
	output logic o_mem_wide,
	output logic o_mem_ext,
	output logic o_mem_io,
	output logic [1:0] o_mem_space,
	output logic [ADDR_W-1:0] o_mem_addr,
	output logic [DATA_W-1:0] o_mem_wdata,
	input wire logic [DATA_W-1:0] i_mem_rdata,
	output logic o_cpu_hold,
	// Status
	output logic [NUM_CH-1:0] o_ch_busy,
	output logic [NUM_CH-1:0] o_ch_done,
	output logic [NUM_CH-1:0] o_ch_refused
);
	sdma_state_t state;
	sdma_state_t next_state;
	logic [CNT_W-1:0] cyc;
	logic [CH_W-1:0] cur;
	logic [CH_W-1:0] rr_last;
	logic [NUM_CH-1:0] active;
	logic [ADDR_W-1:0] src_addr [NUM_CH];
	logic [ADDR_W-1:0] dst_addr [NUM_CH];
	logic [15:0] remain [NUM_CH];
	logic host_we;
	logic [ADDR_W-1:0] host_addr;
	logic [15:0] host_wdata;

	sdma_fifo_if #(.WIDTH(DATA_W)) buf_if ();
	// Element buffer between read and write phases
	sdma_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_buf (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.fifo(buf_if.buffer)
	);

	// Per-channel decode of mode, legality and readiness
	logic [NUM_CH-1:0] ch_ready;
	logic [NUM_CH-1:0] ch_legal;
	logic [NUM_CH-1:0] ch_src_ext;
	logic [NUM_CH-1:0] ch_dst_ext;
	logic [NUM_CH-1:0] ch_wide;
	logic [NUM_CH-1:0] ch_evt;
	logic [1:0] ch_src_adj [NUM_CH];
	logic [1:0] ch_dst_adj [NUM_CH];
	logic [1:0] ch_src_spc [NUM_CH];
	logic [1:0] ch_dst_spc [NUM_CH];
	logic [NUM_CH-1:0] ch_wsync;
	logic [NUM_CH-1:0] ch_start;
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			wire [MODE_W-1:0] m = i_channel_transfer_mode_reg[g*MODE_W +: MODE_W];
			wire [3:0] sel = i_sync_event_select[g*4 +: 4];
			assign ch_src_ext[g] = m[MODE_SRC_EXT_BIT];
			assign ch_dst_ext[g] = m[MODE_DST_EXT_BIT];
			assign ch_src_adj[g] = m[MODE_SRC_ADJ_LO +: 2];
			assign ch_dst_adj[g] = m[MODE_DST_ADJ_LO +: 2];
			assign ch_src_spc[g] = m[MODE_SRC_SPC_LO +: 2];
			assign ch_dst_spc[g] = m[MODE_DST_SPC_LO +: 2];
			assign ch_wsync[g] = m[MODE_W_SYNC_BIT];
			// Wide elements only when both ends are internal
			assign ch_wide[g] = m[MODE_WIDE_BIT] && !ch_src_ext[g] && !ch_dst_ext[g];
			// Peripheral side is the I/O FIFO or offsets 20 to 5f in any page
			wire src_per = (ch_src_spc[g] == SPACE_IO)
				|| (ch_src_adr_mmr(src_addr[g]));
			wire dst_per = (ch_dst_spc[g] == SPACE_IO)
				|| (ch_src_adr_mmr(dst_addr[g]));
			// Barred combinations and external channel ownership
			assign ch_legal[g] = !(ch_src_ext[g] && ch_dst_ext[g])
				&& !(src_per && ch_dst_ext[g]) && !(ch_src_ext[g] && dst_per)
				&& (!ch_src_ext[g] || i_ext_read_ch == CH_W'(g))
				&& (!ch_dst_ext[g] || i_ext_write_ch == CH_W'(g));
			// Reserved sync codes never fire; external phases ignore sync
			assign ch_evt[g] = (sel == SYNC_NONE) || ((sel <= SYNC_LAST)
				&& i_sync_events[sel[2:0] - 3'h1]);
			assign ch_start[g] = ch_wsync[g] ? 1'b1 : (ch_evt[g] || ch_src_ext[g]);
			assign ch_ready[g] = active[g] && ch_legal[g] && ch_start[g];
		end
	endgenerate

	// Locations 20,21,30,31,40,41 read-only, 22,23,32,33,42,43 write-only
	function automatic logic ch_src_adr_mmr(input logic [ADDR_W-1:0] a);
		ch_src_adr_mmr = (a[15:0] >= MMR_LO) && (a[15:0] <= MMR_HI);
	endfunction
	function automatic logic mmr_ok(input logic [ADDR_W-1:0] a, input logic wr);
		logic [7:0] lo;
		logic in_win;
		lo = a[7:0];
		in_win = ch_src_adr_mmr(a) && (a[PAGE_LO +: 7] == 7'h00 || a[PAGE_LO +: 7] == 7'h02);
		if (!in_win)
			mmr_ok = 1'b1;
		else if ((lo[3:0] >= 4'h4) || (lo[7:4] == 4'h5))
			mmr_ok = 1'b0;
		else
			mmr_ok = wr ? lo[1] : !lo[1];
	endfunction

	// Priority pick: highest priority, rotate among equals
	logic [CH_W-1:0] pick;
	logic pick_ok;
	always_comb begin
		logic [CH_W-1:0] idx;
		logic [PRIO_W-1:0] best;
		pick = '0;
		pick_ok = 1'b0;
		best = '0;
		idx = '0;
		for (int k = 1; k <= NUM_CH; k++) begin
			idx = CH_W'((int'(rr_last) + k) % NUM_CH);
			if (ch_ready[idx] && (!pick_ok
				|| i_ch_priority[idx*PRIO_W +: PRIO_W] > best)) begin
				pick = idx;
				pick_ok = 1'b1;
				best = i_ch_priority[idx*PRIO_W +: PRIO_W];
			end
		end
	end

	// Phase timing: internal two cycles, external minimums
	wire cur_ext_rd = ch_src_ext[cur];
	wire cur_ext_wr = ch_dst_ext[cur];
	wire [CNT_W-1:0] rd_len = cur_ext_rd ? CNT_W'(EXT_RD_CYC) : CNT_W'(PHASE_CYC);
	wire [CNT_W-1:0] wr_len = cur_ext_wr ? CNT_W'(EXT_WR_CYC) : CNT_W'(PHASE_CYC);
	wire phase_end_rd = (cyc == rd_len - 1'b1);
	wire phase_end_wr = (cyc == wr_len - 1'b1);
	wire wr_gate = !ch_wsync[cur] || ch_evt[cur] || cur_ext_wr;
	wire src_ok = mmr_ok(src_addr[cur], 1'b0) && mmr_ok(dst_addr[cur], 1'b1);
	wire last_elem = (remain[cur] == 16'h0001);
	wire host_go = i_host_port_req && !o_host_port_ack;

	// Sequencer: host port takes the shared bus between elements
	always_comb begin
		next_state = state;
		case (state)
			SDMA_IDLE: begin
				if (host_go)
					next_state = SDMA_HOST;
				else if (pick_ok && buf_if.in_ready)
					next_state = SDMA_READ;
			end
			SDMA_READ: begin
				if (phase_end_rd)
					next_state = SDMA_WRITE;
			end
			SDMA_WRITE: begin
				if (phase_end_wr && wr_gate)
					next_state = SDMA_NEXT;
			end
			SDMA_HOST: begin
				if (cyc == CNT_W'(PHASE_CYC - 1))
					next_state = SDMA_IDLE;
			end
			SDMA_NEXT: next_state = SDMA_IDLE;
			default: next_state = SDMA_IDLE;
		endcase
	end

	// Element path through the buffer
	wire rd_capture = (state == SDMA_READ) && phase_end_rd;
	assign buf_if.in_valid = rd_capture && src_ok;
	assign buf_if.in_data = i_mem_rdata;
	assign buf_if.out_ready = (state == SDMA_WRITE) && phase_end_wr && wr_gate;

	// Address adjust after each element
	function automatic logic [ADDR_W-1:0] adjust(input logic [ADDR_W-1:0] a,
		input logic [1:0] mode, input logic wide);
		logic [ADDR_W-1:0] step;
		step = wide ? ADDR_W'(2) : ADDR_W'(1);
		case (mode)
			ADJ_HOLD: adjust = a;
			ADJ_INC: adjust = a + step;
			ADJ_DEC: adjust = a - step;
			ADJ_INDEX: adjust = a + ADDR_W'(signed'(i_index));
			default: adjust = a;
		endcase
	endfunction

	// Bus drive decode for the current phase
	wire in_rd = (state == SDMA_READ);
	wire in_wr = (state == SDMA_WRITE);
	wire in_host = (state == SDMA_HOST);
	wire [1:0] next_space = in_rd ? ch_src_spc[cur] : ch_dst_spc[cur];
	wire next_ext = (in_rd && cur_ext_rd) || (in_wr && cur_ext_wr);
	wire [ADDR_W-1:0] raw_addr = in_host ? host_addr : (in_rd ? src_addr[cur] : dst_addr[cur]);
	// External pages alias to the low three page bits
	wire [ADDR_W-1:0] next_addr = next_ext
		? {{(ADDR_W-PAGE_LO-EXT_PAGE_W){1'b0}}, raw_addr[PAGE_LO +: EXT_PAGE_W],
			raw_addr[PAGE_LO-1:0]} : raw_addr;
	wire next_req = (in_rd || (in_wr && wr_gate)) && src_ok || in_host;

	// State, phase counter and current channel
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= SDMA_IDLE;
			cyc <= '0;
			cur <= '0;
			rr_last <= CH_W'(NUM_CH - 1);
		end else begin
			state <= next_state;
			cyc <= (next_state != state) ? '0 : (in_wr && !wr_gate) ? cyc : cyc + 1'b1;
			if (state == SDMA_IDLE && next_state == SDMA_READ) begin
				cur <= pick;
				rr_last <= pick;
			end
		end
	end

	// Channel contexts: load on enable, step after each element
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ctx
			wire load = i_ch_enable[g] && !active[g] && !o_ch_done[g];
			wire step = (state == SDMA_NEXT) && (cur == CH_W'(g));
			always_ff @(posedge i_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					active[g] <= 1'b0;
					src_addr[g] <= '0;
					dst_addr[g] <= '0;
					remain[g] <= '0;
					o_ch_done[g] <= 1'b0;
					o_ch_refused[g] <= 1'b0;
				end else if (!i_ch_enable[g]) begin
					active[g] <= 1'b0;
					o_ch_done[g] <= 1'b0;
					o_ch_refused[g] <= 1'b0;
				end else if (load) begin
					active[g] <= (i_ch_count[g*16 +: 16] != 16'h0000);
					src_addr[g] <= i_ch_src_start[g*ADDR_W +: ADDR_W];
					dst_addr[g] <= i_ch_dst_start[g*ADDR_W +: ADDR_W];
					remain[g] <= i_ch_count[g*16 +: 16];
					o_ch_done[g] <= (i_ch_count[g*16 +: 16] == 16'h0000);
				end else begin
					o_ch_refused[g] <= active[g] && !ch_legal[g];
					if (step) begin
						src_addr[g] <= adjust(src_addr[g], ch_src_adj[g], ch_wide[g]);
						dst_addr[g] <= adjust(dst_addr[g], ch_dst_adj[g], ch_wide[g]);
						remain[g] <= remain[g] - 16'h0001;
						active[g] <= !last_elem;
						o_ch_done[g] <= last_elem;
					end
				end
			end
		end
	endgenerate

	// Host port request capture and answer
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			host_we <= 1'b0;
			host_addr <= '0;
			host_wdata <= '0;
			o_host_port_ack <= 1'b0;
			o_host_port_rdata <= '0;
		end else begin
			if (state == SDMA_IDLE && host_go) begin
				host_we <= i_host_port_write;
				host_addr <= i_host_port_addr;
				host_wdata <= i_host_port_wdata;
			end
			o_host_port_ack <= in_host && (cyc == CNT_W'(PHASE_CYC - 1));
			if (in_host && !host_we && cyc == CNT_W'(PHASE_CYC - 1))
				o_host_port_rdata <= i_mem_rdata[15:0];
		end
	end

	// Registered bus drive
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_mem_req <= 1'b0;
			o_mem_write <= 1'b0;
			o_mem_wide <= 1'b0;
			o_mem_ext <= 1'b0;
			o_mem_io <= 1'b0;
			o_mem_space <= SPACE_PROG;
			o_mem_addr <= '0;
			o_mem_wdata <= '0;
			o_cpu_hold <= 1'b0;
			o_ch_busy <= '0;
		end else begin
			o_mem_req <= next_req;
			o_mem_write <= next_req && (in_wr || (in_host && host_we));
			o_mem_wide <= (in_rd || in_wr) && ch_wide[cur];
			o_mem_ext <= next_ext;
			o_mem_io <= !in_host && next_space == SPACE_IO;
			o_mem_space <= in_host ? SPACE_DATA : next_space;
			o_mem_addr <= next_addr;
			o_mem_wdata <= in_host ? {16'h0000, host_wdata} : buf_if.out_data;
			o_cpu_hold <= next_req && !next_ext;
			o_ch_busy <= active;
		end
	end
endmodule // sdma_engine

/* logic/sdma_fifo.sv */
// Element buffer between read and write phases, flip-flop storage.
// Assumes the engine drains it and stalls when it is full.
`timescale 1ns/10ps
module sdma_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Engine side
	sdma_fifo_if.buffer fifo
);
	localparam int PTR_W = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W:0] count;
	wire push = fifo.in_valid && fifo.in_ready;
	wire pop = fifo.out_valid && fifo.out_ready;

	// Honest full and empty from the fill count
	assign fifo.in_ready = (count != (PTR_W+1)'(DEPTH));
	assign fifo.out_valid = (count != '0);
	assign fifo.out_data = mem[rd_ptr];

	// Pointers and fill count
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == PTR_W'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == PTR_W'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		end
	end

	// Storage, one entry per write
	always_ff @(posedge i_clk) begin
		if (push)
			mem[wr_ptr] <= fifo.in_data;
	end
endmodule // sdma_fifo

/* logic/sdma_fifo_if.sv */
// Carrier between the engine and its element buffer.
// Assumes one clock for both ends.
`timescale 1ns/10ps
interface sdma_fifo_if #(parameter int WIDTH = 32);
	logic in_valid;
	logic in_ready;
	logic [WIDTH-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [WIDTH-1:0] out_data;
	modport buffer (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport engine (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface // sdma_fifo_if

/* logic/sdma_pkg.sv */
// Package for the six-channel transfer controller: widths, field positions,
// codes and timing counts shared by the engine, its checker, the memory model and the bench.
// Assumes a single 125 MHz clock domain.
package sdma_pkg;
	localparam int NUM_CH = 6;
	localparam int CH_W = 3;
	localparam int ADDR_W = 23;
	localparam int DATA_W = 32;
	localparam int PRIO_W = 2;
	localparam int FIFO_DEPTH = 32;
	// Transfer mode field positions
	localparam int MODE_W = 16;
	localparam int MODE_DST_EXT_BIT = 5;
	localparam int MODE_SRC_EXT_BIT = 11;
	localparam int MODE_DST_ADJ_LO = 2;
	localparam int MODE_SRC_ADJ_LO = 8;
	localparam int MODE_DST_SPC_LO = 0;
	localparam int MODE_SRC_SPC_LO = 6;
	localparam int MODE_WIDE_BIT = 12;
	localparam int MODE_W_SYNC_BIT = 13;
	localparam logic [MODE_W-1:0] MODE_RESET = 16'h0000;
	// Address space select codes
	localparam logic [1:0] SPACE_PROG = 2'h0;
	localparam logic [1:0] SPACE_DATA = 2'h1;
	localparam logic [1:0] SPACE_IO = 2'h2;
	// Address adjust codes
	localparam logic [1:0] ADJ_HOLD = 2'h0;
	localparam logic [1:0] ADJ_INC = 2'h1;
	localparam logic [1:0] ADJ_DEC = 2'h2;
	localparam logic [1:0] ADJ_INDEX = 2'h3;
	// Sync event codes
	localparam logic [3:0] SYNC_NONE = 4'h0;
	localparam logic [3:0] SYNC_LAST = 4'h8;
	localparam int NUM_EVENTS = 8;
	// Register window in pages 00 and 02
	localparam logic [15:0] MMR_LO = 16'h0020;
	localparam logic [15:0] MMR_HI = 16'h005f;
	localparam int EXT_PAGE_W = 3;
	localparam int PAGE_LO = 16;
	// Timing
	localparam int CLK_MHZ = 125;
	localparam int PHASE_CYC = 2;
	localparam int EXT_WR_NS = 72;
	localparam int EXT_RD_NS = 104;
	localparam int EXT_WR_CYC = (EXT_WR_NS * CLK_MHZ + 999) / 1000;
	localparam int EXT_RD_CYC = (EXT_RD_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 5;
	typedef enum logic [2:0] {
		SDMA_IDLE = 3'b000,
		SDMA_READ = 3'b001,
		SDMA_WRITE = 3'b010,
		SDMA_HOST = 3'b011,
		SDMA_NEXT = 3'b100
	} sdma_state_t;
endpackage

/* verification/sdma_engine_checker.sv */
// Port-level checks for the transfer engine, bound to sdma_engine.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps
module sdma_engine_checker (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Watched outputs
	input wire logic o_host_port_ack,
	input wire logic o_mem_req,
	input wire logic o_mem_write,
	input wire logic o_mem_wide,
	input wire logic o_mem_ext,
	input wire logic o_mem_io,
	input wire logic [1:0] o_mem_space,
	input wire logic [sdma_pkg::ADDR_W-1:0] o_mem_addr,
	input wire logic o_cpu_hold,
	input wire logic [sdma_pkg::NUM_CH-1:0] o_ch_done,
	input wire logic [sdma_pkg::NUM_CH-1:0] o_ch_refused
);
	import sdma_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// Phase and register window decode
	wire act = o_mem_req || o_mem_write;
	wire ext_act = act && o_mem_ext;
	wire in_win = o_mem_addr[22:16] inside {7'h00, 7'h02}
		&& o_mem_addr[15:0] >= MMR_LO && o_mem_addr[15:0] <= MMR_HI;
	wire rd_ok = o_mem_addr[7:0] inside {8'h20, 8'h21, 8'h30, 8'h31, 8'h40, 8'h41};
	wire wr_ok = o_mem_addr[7:0] inside {8'h22, 8'h23, 8'h32, 8'h33, 8'h42, 8'h43};
	logic [5:0] ext_run;
	// Length of the external phase in progress
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ext_run <= 6'h00;
		end else begin
			ext_run <= ext_act ? ext_run + 6'h01 : 6'h00;
		end
	end
	sequence s_rd_two;
		(o_mem_req && !o_mem_write)[*2];
	endsequence
	sequence s_rd_end;
		!(o_mem_req && !o_mem_write);
	endsequence
	property p_rd_len;
		$rose(o_mem_req && !o_mem_write) && !o_mem_ext |-> s_rd_two ##1 s_rd_end;
	endproperty
	property p_ext_narrow;
		ext_act |-> !o_mem_wide;
	endproperty
	property p_io_fifo;
		act && !o_mem_ext |-> o_mem_io == (o_mem_space == SPACE_IO);
	endproperty
	property p_cpu_wait;
		act && !o_mem_ext && !o_mem_io |-> o_cpu_hold;
	endproperty
	property p_ext_time;
		$fell(ext_act) |-> ext_run >= ($past(o_mem_write) ? 6'h09 : 6'h0d);
	endproperty
	property p_alias;
		ext_act |-> o_mem_addr[22:19] == 4'h0;
	endproperty
	property p_window;
		act && !o_mem_ext && !o_mem_io && in_win |-> (o_mem_write ? wr_ok : rd_ok);
	endproperty
	property p_ack_pulse;
		o_host_port_ack |=> !o_host_port_ack;
	endproperty
	property p_refuse;
		o_ch_refused != '0 |-> (o_ch_refused & o_ch_done) == '0;
	endproperty
	a_rd_len: assert property (p_rd_len) else $error("internal read phase length wrong");
	a_ext_narrow: assert property (p_ext_narrow) else $error("wide external access");
	a_io_fifo: assert property (p_io_fifo) else $error("io space not routed to fifo");
	a_cpu_wait: assert property (p_cpu_wait) else $error("cpu not held off");
	a_ext_time: assert property (p_ext_time) else $error("external phase too short");
	a_alias: assert property (p_alias) else $error("external page not aliased");
	a_window: assert property (p_window) else $error("register window access");
	a_ack_pulse: assert property (p_ack_pulse) else $error("host ack longer than one cycle");
	a_refuse: assert property (p_refuse) else $error("refused channel completed");
endmodule // sdma_engine_checker

bind sdma_engine sdma_engine_checker u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
	.o_host_port_ack(o_host_port_ack), .o_mem_req(o_mem_req), .o_mem_write(o_mem_write),
	.o_mem_wide(o_mem_wide), .o_mem_ext(o_mem_ext), .o_mem_io(o_mem_io),
	.o_mem_space(o_mem_space), .o_mem_addr(o_mem_addr), .o_cpu_hold(o_cpu_hold),
	.o_ch_done(o_ch_done), .o_ch_refused(o_ch_refused));

/* verification/sdma_mem_model.sv */
// Behavioural memory, peripheral and fifo side seen by the transfer engine.
// Assumes the engine holds address and phase flags for a whole phase.
`timescale 1ns/10ps
module sdma_mem_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Engine bus
	input wire logic i_req,
	input wire logic i_write,
	input wire logic [sdma_pkg::ADDR_W-1:0] i_addr,
	output logic [sdma_pkg::DATA_W-1:0] o_rdata
);
	import sdma_pkg::*;
	logic [DATA_W-1:0] churn;
	// Filler that changes every cycle so an idle bus never looks valid
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			churn <= 32'h1357_9bdf;
		end else begin
			churn <= {churn[30:0], churn[31] ^ churn[27]} ^ 32'h0000_0001;
		end
	end
	// Read data is a fixed function of the address
	assign o_rdata = (i_req && !i_write) ?
		{~i_addr[15:0], i_addr[15:0] ^ {i_addr[22:16], 9'h000}} : churn;
endmodule // sdma_mem_model

/* verification/test_six_channel_dma_controller.sv */
// Self-checking bench for the six-channel transfer engine.
// Assumes sdma_mem_model on the bus and the bound port checker.
`timescale 1ns/10ps
module test_six_channel_dma_controller;
	import sdma_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [NUM_CH-1:0] en = '0;
	logic [NUM_CH*MODE_W-1:0] mode_v = '0;
	logic [NUM_CH*4-1:0] sync_v = '0;
	logic [NUM_CH*PRIO_W-1:0] prio_v = '0;
	logic [NUM_CH*ADDR_W-1:0] src_v = '0;
	logic [NUM_CH*ADDR_W-1:0] dst_v = '0;
	logic [NUM_CH*16-1:0] cnt_v = '0;
	logic [15:0] idx = 16'h0000;
	logic [NUM_EVENTS-1:0] ev = '0;
	logic hreq = 1'b0;
	logic [ADDR_W-1:0] haddr = '0;
	logic prev_w = 1'b0;
	logic hack, mreq, mwr;
	logic [15:0] hrd;
	logic [ADDR_W-1:0] maddr;
	logic [DATA_W-1:0] mwd, mrd;
	logic [NUM_CH-1:0] done, refused;
	logic [ADDR_W+15:0] wr_q[$];
	int bad_count = 0;
	int checked = 0;
	sdma_engine dut (.i_clk(clk), .i_rstn(rstn), .i_ch_enable(en),
		.i_channel_transfer_mode_reg(mode_v), .i_sync_event_select(sync_v),
		.i_ch_priority(prio_v), .i_ch_src_start(src_v), .i_ch_dst_start(dst_v),
		.i_ch_count(cnt_v), .i_index(idx), .i_ext_read_ch(3'h3), .i_ext_write_ch(3'h4),
		.i_sync_events(ev), .i_host_port_req(hreq), .i_host_port_write(1'b0),
		.i_host_port_addr(haddr), .i_host_port_wdata(16'h0000), .o_host_port_ack(hack),
		.o_host_port_rdata(hrd), .o_mem_req(mreq), .o_mem_write(mwr), .o_mem_wide(),
		.o_mem_ext(), .o_mem_io(), .o_mem_space(), .o_mem_addr(maddr), .o_mem_wdata(mwd),
		.i_mem_rdata(mrd), .o_cpu_hold(), .o_ch_busy(), .o_ch_done(done),
		.o_ch_refused(refused));
	sdma_mem_model u_mem (.i_clk(clk), .i_rstn(rstn), .i_req(mreq), .i_write(mwr),
		.i_addr(maddr), .o_rdata(mrd));
	always #4 clk = ~clk;
	// Record each element write as its write phase opens
	always @(posedge clk) begin
		prev_w <= mwr;
		if (mwr && !prev_w) wr_q.push_back({maddr, mwd[15:0]});
	end
	function automatic logic [15:0] pat(input logic [ADDR_W-1:0] a);
		return a[15:0] ^ {a[22:16], 9'h000};
	endfunction
	function automatic logic [ADDR_W-1:0] al(input logic [ADDR_W-1:0] a, input logic x);
		return x ? {4'h0, a[18:0]} : a;
	endfunction
	function automatic logic [ADDR_W-1:0] adv(input logic [ADDR_W-1:0] a, input logic [1:0] j,
		input logic w);
		case (j)
			ADJ_INC: return a + (w ? 23'h000002 : 23'h000001);
			ADJ_DEC: return a - (w ? 23'h000002 : 23'h000001);
			ADJ_INDEX: return a + {{7{idx[15]}}, idx};
			default: return a;
		endcase
	endfunction
	function automatic logic [15:0] md(input logic [1:0] ds, da, ss, sa, input logic de, se, wd);
		return {3'h0, wd, se, 1'b0, sa, ss, de, 1'b0, da, ds};
	endfunction
	task automatic check(input logic ok, input string what);
		checked++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cfg(input int c, input logic [15:0] m, input logic [3:0] sy,
		input logic [ADDR_W-1:0] s, input logic [ADDR_W-1:0] d, input int n);
		@(negedge clk);
		mode_v[c*MODE_W +: MODE_W] = m;
		sync_v[c*4 +: 4] = sy;
		src_v[c*ADDR_W +: ADDR_W] = s;
		dst_v[c*ADDR_W +: ADDR_W] = d;
		cnt_v[c*16 +: 16] = n[15:0];
		prio_v[c*PRIO_W +: PRIO_W] = PRIO_W'($urandom);
		wr_q.delete();
	endtask
	task automatic wait_done(input logic [NUM_CH-1:0] msk, input int lim);
		for (int w = 0; w < lim && (done & msk) !== msk; w++) @(negedge clk);
	endtask
	// Wait for one channel, then compare every element it moved
	task automatic fin(input int c, input logic e, input logic r);
		logic [15:0] m;
		logic [ADDR_W-1:0] s, d;
		int n;
		logic wd;
		m = mode_v[c*MODE_W +: MODE_W];
		// Wide elements step two words, and only when both ends are internal
		wd = m[MODE_WIDE_BIT] && !m[MODE_SRC_EXT_BIT] && !m[MODE_DST_EXT_BIT];
		s = src_v[c*ADDR_W +: ADDR_W];
		d = dst_v[c*ADDR_W +: ADDR_W];
		n = int'(cnt_v[c*16 +: 16]);
		wait_done(6'h01 << c, 300);
		check(done[c] === e, "completion state");
		check(refused[c] === r, "refusal flag");
		check(wr_q.size() == (e ? n : 0), "element count");
		for (int k = 0; k < n && k < wr_q.size(); k++) begin
			check(wr_q[k] === {al(d, m[5]), pat(al(s, m[11]))}, "element addr or data");
			s = adv(s, m[MODE_SRC_ADJ_LO +: 2], wd);
			d = adv(d, m[MODE_DST_ADJ_LO +: 2], wd);
		end
		@(negedge clk);
		en = '0;
	endtask
	task automatic run(input int c, input logic [15:0] m, input logic [3:0] sy,
		input logic [ADDR_W-1:0] s, input logic [ADDR_W-1:0] d, input int n,
		input logic e, input logic r);
		cfg(c, m, sy, s, d, n);
		@(negedge clk);
		en[c] = 1'b1;
		fin(c, e, r);
	endtask
	// Guard against a hang
	initial begin
		#320000;
		bad_count++;
		summarize();
	end
	initial begin
		logic [15:0] mi;
		void'($urandom(57151));
		mi = md(SPACE_DATA, ADJ_INC, SPACE_DATA, ADJ_INC, 1'b0, 1'b0, 1'b0);
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		// Random internal blocks over all channels and adjust codes
		for (int i = 0; i < 12; i++) begin
			idx = 16'($urandom_range(0, 15)) - 16'h0008;
			run(i % 6, md(2'($urandom_range(0, 2)), 2'(i), 2'($urandom_range(0, 2)),
				2'($urandom), 1'b0, 1'b0, 1'($urandom)), 4'h0,
				{7'h01, 16'($urandom_range(256, 61440))}, {7'h03, 16'($urandom_range(256, 61440))},
				$urandom_range(1, 4), 1'b1, 1'b0);
		end
		// External owners with high pages, then register window corners
		run(3, md(SPACE_DATA, ADJ_INC, SPACE_DATA, ADJ_INC, 1'b0, 1'b1, 1'b1), 4'h0,
			23'h7a1230, 23'h015000, 2, 1'b1, 1'b0);
		run(4, md(SPACE_DATA, ADJ_DEC, SPACE_PROG, ADJ_INC, 1'b1, 1'b0, 1'b0), 4'h0,
			23'h016000, 23'h7d0800, 2, 1'b1, 1'b0);
		run(0, mi, 4'h0, 23'h000020, 23'h000022, 2, 1'b1, 1'b0);
		// Combinations that must be refused
		run(3, md(SPACE_IO, ADJ_INC, SPACE_DATA, ADJ_INC, 1'b0, 1'b1, 1'b0), 4'h0,
			23'h010000, 23'h000100, 1, 1'b0, 1'b1);
		run(3, md(SPACE_DATA, ADJ_INC, SPACE_DATA, ADJ_INC, 1'b1, 1'b1, 1'b0), 4'h0,
			23'h010000, 23'h020000, 1, 1'b0, 1'b1);
		run(4, md(SPACE_DATA, ADJ_INC, SPACE_IO, ADJ_INC, 1'b1, 1'b0, 1'b0), 4'h0,
			23'h000100, 23'h020000, 1, 1'b0, 1'b1);
		run(2, md(SPACE_DATA, ADJ_INC, SPACE_DATA, ADJ_INC, 1'b0, 1'b1, 1'b0), 4'h0,
			23'h010000, 23'h021000, 1, 1'b0, 1'b1);
		// Every sync code: codes 1 to 8 held off by foreign events and released by their own, code 0 runs, reserved codes never fire
		for (int k = 0; k < 16; k++) begin
			ev = (k >= 1 && k <= 8) ? ~(8'h01 << (k - 1)) : 8'hff;
			run(1, mi, k[3:0], 23'h012000, 23'h034000, 1, k == 0, 1'b0);
			if (k >= 1 && k <= 8) begin
				ev = 8'h01 << (k - 1);
				run(1, mi, k[3:0], 23'h012000, 23'h034000, 1, 1'b1, 1'b0);
			end
		end
		// Write held by its own event: the read goes ahead, the write waits
		cfg(1, mi | (16'h0001 << MODE_W_SYNC_BIT), 4'h3, 23'h012000, 23'h034000, 1);
		ev = 8'hfb;
		@(negedge clk);
		en[1] = 1'b1;
		repeat (40) @(negedge clk);
		check(wr_q.size() == 0 && done[1] === 1'b0, "write not held off");
		ev = 8'h04;
		fin(1, 1'b1, 1'b0);
		// Two channels started together: higher priority first, equals rotate
		for (int p = 0; p < 3; p++) begin
			cfg(0, mi, 4'h0, 23'h011000, 23'h031000, 1);
			cfg(5, mi, 4'h0, 23'h012000, 23'h032000, 1);
			prio_v = (p == 0) ? 12'h003 : ((p == 1) ? 12'hc00 : 12'h000);
			@(negedge clk);
			en = 6'h21;
			wait_done(6'h21, 300);
			check(wr_q.size() == 2 && wr_q[0][ADDR_W+15:16] ===
				((p == 0) ? 23'h031000 : 23'h032000), "priority order");
			@(negedge clk);
			en = '0;
		end
		// Host port read slips in while a channel runs
		cfg(2, mi, 4'h0, 23'h013000, 23'h033000, 6);
		@(negedge clk);
		en[2] = 1'b1;
		hreq = 1'b1;
		haddr = 23'h000030;
		for (int w = 0; w < 60 && hack !== 1'b1; w++) @(negedge clk);
		check(hack === 1'b1 && hrd === pat(23'h000030), "host read");
		hreq = 1'b0;
		fin(2, 1'b1, 1'b0);
		summarize();
	end
endmodule // test_six_channel_dma_controller
